// File: hw/isd_defs.svh
`ifndef ISD_DEFS_SVH
`define ISD_DEFS_SVH

// ----------------------------------------
// Register map (byte offsets)
// ----------------------------------------
`define ISD_ADR_CTRL   4'h0
`define ISD_ADR_STATUS 4'h4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ISD_CTRL_RST   1'b1
`define ISD_TP_RST     12'h001
`define ISD_OP_RST     7'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ISD_CTRL_RUN   0
`define ISD_ST_OP_LSB  0
`define ISD_ST_STG_LSB 8
`define ISD_ST_BR_LSB  12
`define ISD_ST_SPC_LSB 14
`define ISD_ST_TP_LSB  16

// ----------------------------------------
// Timing and forced codes
// ----------------------------------------
`define ISD_MEMORY_CYCLE_TIME 12
`define ISD_RUPT_CODE  7'h47
`define ISD_STAGE_START 3'h1
`define ISD_STAGE_TCSA  3'h3
`define ISD_ADDR_REL   12'h003
`define ISD_ADDR_INH   12'h004
`define ISD_ADDR_EXT   12'h006

`endif

// File: hw/isd_pkg.sv
`default_nettype none

package isd_pkg;

  typedef struct packed {
    logic       ext;
    logic [7:0] of;
    logic [3:0] qc;
    logic       b10;
  } isd_opdec_t;

  typedef struct packed {
    logic read_z_pulse;
    logic write_q_pulse;
    logic read_sum_pulse;
    logic write_sum_pulse;
    logic test_pulse;
    logic chan_or_pulse;
    logic periph_xfer_pulse;
    logic read_b_pulse;
    logic write_opcode_pulse;
    logic clear_opcode_pulse;
    logic new_instruction_load_pulse;
    logic stage_advance_pulse_a;
    logic stage_advance_pulse_b;
    logic divide_stage_step_pulse;
    logic interrupt_release_instruction;
    logic interrupt_inhibit_instruction;
  } isd_ctrl_t;

  typedef enum logic [1:0] {SPC_NONE, SPC_REL, SPC_INH, SPC_EXT} isd_spec_t;
  typedef enum logic [1:0] {PRQ_NONE, PRQ_FETCH, PRQ_STORE} isd_preq_t;

endpackage

`default_nettype wire

// File: hw/isd_top.sv
// Overview of operation
// - Seven-bit opcode, six bits from write lines
// - Top opcode bit is the extend bit
// - Bits 16,14,13 decode one-hot order field
// - Bits 12,11 decode one of four quarters
// - Bit 10 used only for channel, interrupt
// - Load pulse clears, reads B, writes opcode
// - Start and transfer only clear the opcode
// - Stage starts at 000, advances to 001 or 010
// - Divide steps Gray sequence, ends at 010
// - Stage decoded to binary and Gray codes
// - Forced codes preset stage 000, 001, 011
// - Subinstruction is AND of code signals
// - Shared commands come from ORed subinstructions
// - Peripheral requests latched, sequenced by stage
// - Action pulse is command AND time pulse
// - Shared action pulse from transfer and exchange commands
// - Branch adds extra action pulse
// - Action pulse fans out to control pulses
// - Control pulses steer opcode, branch, datapath
// - Branch stage one sign, two zero
// - Overflow written 01 positive, 10 negative
// - Special flip-flop runs release, inhibit, extend
`include "isd_defs.svh"
`default_nettype none

module isd_top
  import isd_pkg::*;
(
  // Clock and reset
  input  wire  logic        i_core_clk,
  input  wire  logic        i_reset,
  // Wishbone slave
  input  wire  logic        i_wb_cyc,
  input  wire  logic        i_wb_stb,
  input  wire  logic        i_wb_we,
  input  wire  logic [3:0]  i_wb_adr,
  input  wire  logic [31:0] i_wb_dat,
  input  wire  logic [3:0]  i_wb_sel,
  output var   logic [31:0] o_wb_dat,
  output var   logic        o_wb_ack,
  // Datapath
  input  wire  logic [15:0] i_write_lines,
  // Priority control and peripheral equipment
  input  wire  logic        i_force_start,
  input  wire  logic        i_force_tcsa,
  input  wire  logic        i_force_rupt,
  input  wire  logic        i_peripheral_fetch_request,
  input  wire  logic        i_peripheral_store_request,
  // Sequence outputs
  output var   isd_ctrl_t   o_ctrl,
  output var   logic [6:0]  o_opcode,
  output var   logic [2:0]  o_stage,
  output var   logic [1:0]  o_branch,
  output var   logic [11:0] o_time_pulse
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic logic [2:0] gray_step(input logic [2:0] s);
    unique case (s)
      3'h0:    gray_step = 3'h1;
      3'h1:    gray_step = 3'h3;
      3'h3:    gray_step = 3'h7;
      3'h7:    gray_step = 3'h6;
      3'h6:    gray_step = 3'h4;
      default: gray_step = s;
    endcase
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [6:0]  opcode_register_reg;
  logic [2:0]  stage_reg;
  logic [1:0]  branch_reg;
  logic [11:0] tp_reg;
  logic        run_reg;
  logic        new_instruction_load_pulse_latch_reg;
  logic        fut_ext_reg;
  isd_spec_t   spec_reg;
  isd_preq_t   preq_reg;
  isd_ctrl_t   ctrl_next;
  isd_opdec_t  opdec;
  logic [11:0] t;
  logic [3:0]  bin;
  logic [5:0]  gray;
  logic        pact;
  logic        extend_bit_signal;
  logic        order_field_decode_zero;
  logic        quarter_code_two;
  logic        bit_ten_signal;
  logic        stage_code_zero;
  logic        transfer_first_step;
  logic        double_add_first_step;
  logic        l_exchange_first_step;
  logic        double_exchange_first_step;
  logic        channel_or_first_step;
  logic        shared_exchange_command;
  logic        action_pulse_three_six;
  logic        divide_cmd;
  logic        rupt_first_step;
  logic        fetch_first_step;
  logic        store_first_step;
  logic        advance_cmd;
  logic        load_now;
  logic        wb_req;

  // ----------------------------------------
  // Opcode and stage decoders
  // ----------------------------------------
  always_comb begin
    opdec.ext = opcode_register_reg[6];
    opdec.of  = 8'h01 << opcode_register_reg[5:3];
    opdec.qc  = 4'h1 << opcode_register_reg[2:1];
    opdec.b10 = opcode_register_reg[0];
  end

  assign bin  = {stage_reg == 3'h3, stage_reg == 3'h2,
                 stage_reg == 3'h1, stage_reg == 3'h0};
  assign gray = {stage_reg == 3'h4, stage_reg == 3'h6, stage_reg == 3'h7,
                 stage_reg == 3'h3, stage_reg == 3'h1, stage_reg == 3'h0};

  assign extend_bit_signal       = opdec.ext;
  assign order_field_decode_zero = opdec.of[0];
  assign quarter_code_two        = opdec.qc[2];
  assign bit_ten_signal          = opdec.b10;
  assign stage_code_zero         = bin[0];
  assign pact                    = preq_reg != PRQ_NONE;

  // ----------------------------------------
  // Command generator
  // ----------------------------------------
  // Bit 10 is left out of all terms but channel OR and interrupt
  assign transfer_first_step = ~pact & ~opdec.ext & opdec.of[0]
                             & stage_code_zero;
  assign double_add_first_step = ~pact & ~opdec.ext & opdec.of[2] & opdec.qc[0]
                               & stage_code_zero;
  assign l_exchange_first_step = ~pact & ~opdec.ext & opdec.of[2] & opdec.qc[1]
                               & stage_code_zero;
  assign double_exchange_first_step = ~pact & ~opdec.ext & opdec.of[5]
                                    & opdec.qc[1] & stage_code_zero;
  assign divide_cmd = ~pact & opdec.ext & opdec.of[1] & opdec.qc[0];
  assign channel_or_first_step = ~pact & extend_bit_signal & order_field_decode_zero
                               & quarter_code_two & bit_ten_signal
                               & stage_code_zero;
  assign rupt_first_step = ~pact & opdec.ext & opdec.of[0] & opdec.qc[3]
                         & opdec.b10 & stage_code_zero;
  assign fetch_first_step = (preq_reg == PRQ_FETCH) & bin[0];
  assign store_first_step = (preq_reg == PRQ_STORE) & bin[0];
  assign shared_exchange_command = double_exchange_first_step
                                 | l_exchange_first_step;
  assign advance_cmd = double_add_first_step | double_exchange_first_step
                     | rupt_first_step | fetch_first_step | store_first_step;

  // ----------------------------------------
  // Crosspoint generator and control gates
  // ----------------------------------------
  assign t = run_reg ? tp_reg : 12'h000;

  // Extra pulse when branch shows positive overflow
  assign action_pulse_three_six = (t[0] & (transfer_first_step | shared_exchange_command))
                                | (t[8] & double_add_first_step
                                   & (branch_reg == 2'h1));

  always_comb begin
    ctrl_next = '0;
    ctrl_next.read_z_pulse   = action_pulse_three_six;
    ctrl_next.write_q_pulse  = action_pulse_three_six;
    ctrl_next.read_sum_pulse = t[4] & double_add_first_step;
    ctrl_next.write_sum_pulse = t[4] & double_add_first_step;
    ctrl_next.test_pulse = t[6] & (double_add_first_step | divide_cmd
                                   | channel_or_first_step);
    ctrl_next.chan_or_pulse = t[4] & channel_or_first_step;
    ctrl_next.periph_xfer_pulse = t[4] & (fetch_first_step | store_first_step);
    ctrl_next.stage_advance_pulse_a = t[11] & advance_cmd;
    ctrl_next.stage_advance_pulse_b = t[11] & divide_cmd & gray[5];
    ctrl_next.divide_stage_step_pulse = t[11] & divide_cmd & (|gray[4:0]);
    ctrl_next.new_instruction_load_pulse = t[10] & ~advance_cmd
                                         & ~(divide_cmd & ~bin[2]);
    ctrl_next.interrupt_release_instruction = t[7] & (spec_reg == SPC_REL);
    ctrl_next.interrupt_inhibit_instruction = t[7] & (spec_reg == SPC_INH);
    ctrl_next.clear_opcode_pulse = i_force_start | (t[11] & new_instruction_load_pulse_latch_reg);
    ctrl_next.read_b_pulse = load_now;
    ctrl_next.write_opcode_pulse = load_now;
  end

  assign load_now = t[11] & new_instruction_load_pulse_latch_reg & ~i_force_start & ~i_force_tcsa
                  & ~(i_force_rupt & ~fut_ext_reg) & ~pact
                  & ~i_peripheral_fetch_request & ~i_peripheral_store_request;

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      o_ctrl <= '0;
    end else begin
      o_ctrl <= ctrl_next;
    end
  end

  // ----------------------------------------
  // Time pulse generator
  // ----------------------------------------
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      tp_reg <= `ISD_TP_RST;
    end else if (run_reg) begin
      tp_reg <= {tp_reg[10:0], tp_reg[11]};
    end
  end

  // ----------------------------------------
  // Order code processor
  // ----------------------------------------
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      new_instruction_load_pulse_latch_reg <= 1'b0;
    end else if (i_force_start || t[11]) begin
      new_instruction_load_pulse_latch_reg <= 1'b0;
    end else if (ctrl_next.new_instruction_load_pulse) begin
      new_instruction_load_pulse_latch_reg <= 1'b1;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      opcode_register_reg <= `ISD_OP_RST;
      stage_reg           <= 3'h0;
      preq_reg            <= PRQ_NONE;
    end else if (i_force_start) begin
      opcode_register_reg <= 7'h00;
      stage_reg           <= `ISD_STAGE_START;
      preq_reg            <= PRQ_NONE;
    end else if (t[11] && new_instruction_load_pulse_latch_reg) begin
      stage_reg <= 3'h0;
      preq_reg  <= PRQ_NONE;
      if (i_peripheral_fetch_request) begin
        preq_reg <= PRQ_FETCH;
      end else if (i_peripheral_store_request) begin
        preq_reg <= PRQ_STORE;
      end else if (i_force_tcsa) begin
        opcode_register_reg <= 7'h00;
        stage_reg           <= `ISD_STAGE_TCSA;
      end else if (i_force_rupt && !fut_ext_reg) begin
        opcode_register_reg <= `ISD_RUPT_CODE;
      end else begin
        opcode_register_reg <= {fut_ext_reg, i_write_lines[15],
                                i_write_lines[13:9]};
      end
    end else if (ctrl_next.divide_stage_step_pulse) begin
      stage_reg <= gray_step(stage_reg);
    end else if (ctrl_next.stage_advance_pulse_b) begin
      stage_reg <= 3'h2;
    end else if (ctrl_next.stage_advance_pulse_a) begin
      stage_reg <= stage_reg | 3'h1;
    end
  end

  // ----------------------------------------
  // Branch control
  // ----------------------------------------
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      branch_reg <= 2'h0;
    end else if (ctrl_next.test_pulse) begin
      if (i_write_lines[15] != i_write_lines[14]) begin
        branch_reg <= i_write_lines[15] ? 2'h2 : 2'h1;
      end else begin
        branch_reg <= {i_write_lines[15],
                       (i_write_lines == 16'h0000)
                       | (i_write_lines == 16'hFFFF)};
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      spec_reg <= SPC_NONE;
    end else if (i_force_start || t[11]) begin
      spec_reg <= SPC_NONE;
    end else if (t[0] && transfer_first_step) begin
      unique case (i_write_lines[11:0])
        `ISD_ADDR_REL: spec_reg <= SPC_REL;
        `ISD_ADDR_INH: spec_reg <= SPC_INH;
        `ISD_ADDR_EXT: spec_reg <= SPC_EXT;
        default:       spec_reg <= SPC_NONE;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      fut_ext_reg <= 1'b0;
    end else if (i_force_start || load_now) begin
      fut_ext_reg <= 1'b0;
    end else if (t[7] && spec_reg == SPC_EXT) begin
      fut_ext_reg <= 1'b1;
    end
  end

  // ----------------------------------------
  // Wishbone slave
  // ----------------------------------------
  assign wb_req = i_wb_cyc & i_wb_stb;

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else begin
      o_wb_ack <= wb_req & ~o_wb_ack;
      o_wb_dat <= 32'h0000_0000;
      if (wb_req && !o_wb_ack && !i_wb_we) begin
        unique case (i_wb_adr)
          `ISD_ADR_CTRL: o_wb_dat[`ISD_CTRL_RUN] <= run_reg;
          `ISD_ADR_STATUS: begin
            o_wb_dat[`ISD_ST_OP_LSB +: 7]  <= opcode_register_reg;
            o_wb_dat[`ISD_ST_STG_LSB +: 3] <= stage_reg;
            o_wb_dat[`ISD_ST_BR_LSB +: 2]  <= branch_reg;
            o_wb_dat[`ISD_ST_SPC_LSB +: 2] <= spec_reg;
            o_wb_dat[`ISD_ST_TP_LSB +: 12] <= tp_reg;
          end
          default: o_wb_dat <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Write lands on the edge where the master sees ack
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      run_reg <= `ISD_CTRL_RST;
    end else if (wb_req && o_wb_ack && i_wb_we && i_wb_sel[0]
                 && i_wb_adr == `ISD_ADR_CTRL) begin
      run_reg <= i_wb_dat[`ISD_CTRL_RUN];
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign o_opcode     = opcode_register_reg;
  assign o_stage      = stage_reg;
  assign o_branch     = branch_reg;
  assign o_time_pulse = tp_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  sequence normal_load_s;
    load_now ##1 o_ctrl.write_opcode_pulse;
  endsequence

  sequence divide_end_s;
    t[11] && divide_cmd && stage_reg == 3'h4 && !new_instruction_load_pulse_latch_reg && !i_force_start;
  endsequence

  opcode_load_a: assert property (normal_load_s |-> o_opcode[5:0] ==
      {$past(i_write_lines[15], 1), $past(i_write_lines[13:9], 1)})
    else $error("opcode not loaded from write lines");
  extend_bit_a: assert property (load_now |=> o_opcode[6] == $past(fut_ext_reg))
    else $error("extend bit wrong after load");
  order_onehot_a: assert property ($onehot(opdec.of))
    else $error("order field not one-hot");
  quarter_onehot_a: assert property ($onehot(opdec.qc))
    else $error("quarter code not one-hot");
  start_force_a: assert property (i_force_start |=>
      o_opcode == 7'h00 && o_stage == 3'h1)
    else $error("start did not preset opcode and stage");
  new_stage_a: assert property (load_now |=> o_stage == 3'h0)
    else $error("stage not cleared on new instruction");
  divide_end_a: assert property (divide_end_s |=> o_stage == 3'h2 &&
      o_ctrl.stage_advance_pulse_b)
    else $error("divide did not finish at 010");
  overflow_pos_a: assert property (ctrl_next.test_pulse &&
      i_write_lines[15:14] == 2'h1 |=> o_branch == 2'h1 && o_ctrl.test_pulse)
    else $error("positive overflow not recorded");
  fanout_pair_a: assert property (action_pulse_three_six |=>
      o_ctrl.read_z_pulse && o_ctrl.write_q_pulse)
    else $error("action pulse not split");
  double_add_a: assert property (t[4] && double_add_first_step |=>
      o_ctrl.read_sum_pulse && o_time_pulse[5])
    else $error("double add pulse missing at T05");

endmodule

`default_nettype wire

// File: testbench/isd_datapath_model.sv
`default_nettype none

// ----------------------------------------
// Write lines as driven by the datapath
// ----------------------------------------
module isd_datapath_model (
  // Sequencer timing
  input  wire logic [11:0] i_time_pulse,
  // Register B content and test operand
  input  wire logic [15:0] i_reg_b,
  input  wire logic [15:0] i_data_word,
  // Write lines
  output var  logic [15:0] o_write_lines
);
  timeunit 1ns;
  timeprecision 1ns;

  // B on the lines during the load period, operand otherwise
  always_comb begin
    o_write_lines = i_time_pulse[11] ? i_reg_b : i_data_word;
  end
endmodule

`default_nettype wire

// File: testbench/test_isd_top.sv
`default_nettype none

`define CHECK(got, exp, msg) begin samples_checked++; if ((got) !== (exp)) begin fail_count++; \
  $display("MISMATCH t=%0t %s", $time, msg); end end

module test_isd_top;
  import isd_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [3:0]  sel = 4'h0;
  logic [31:0] rdat_w;
  logic        ack;
  logic [15:0] wl;
  logic [15:0] reg_b = 16'h0000;
  logic [15:0] data_word = 16'h0000;
  logic [2:0]  force_v = 3'h0;
  logic        fetch_rq = 1'b0;
  logic        store_rq = 1'b0;
  isd_ctrl_t   ctrl;
  logic [6:0]  opcode;
  logic [2:0]  stage;
  logic [1:0]  branch;
  logic [11:0] tp;
  int          fail_count = 0;
  int          samples_checked = 0;

  always #25 clk = ~clk;

  isd_top isd_top_i (
    .i_core_clk                 (clk),
    .i_reset                    (rst),
    .i_wb_cyc                   (cyc),
    .i_wb_stb                   (stb),
    .i_wb_we                    (we),
    .i_wb_adr                   (adr),
    .i_wb_dat                   (wdat),
    .i_wb_sel                   (sel),
    .o_wb_dat                   (rdat_w),
    .o_wb_ack                   (ack),
    .i_write_lines              (wl),
    .i_force_start              (force_v[0]),
    .i_force_tcsa               (force_v[1]),
    .i_force_rupt               (force_v[2]),
    .i_peripheral_fetch_request (fetch_rq),
    .i_peripheral_store_request (store_rq),
    .o_ctrl                     (ctrl),
    .o_opcode                   (opcode),
    .o_stage                    (stage),
    .o_branch                   (branch),
    .o_time_pulse               (tp)
  );

  isd_datapath_model isd_datapath_model_i (
    .i_time_pulse  (tp),
    .i_reg_b       (reg_b),
    .i_data_word   (data_word),
    .o_write_lines (wl)
  );

  // ----------------------------------------
  // Bus and wait tasks
  // ----------------------------------------
  task automatic wb_xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
                         output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= 4'hF;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    r = rdat_w;
    if (n >= 50) begin
      fail_count++;
      $display("MISMATCH t=%0t bus answer missing", $time);
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  // Waits until the given time pulse bit is up, seen at a falling edge
  task automatic wait_tp(input int b);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (tp[b] !== 1'b1 && n < 40);
    `CHECK(tp[b], 1'b1, "time pulse missing")
  endtask

  task automatic wait_load();
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (ctrl.write_opcode_pulse !== 1'b1 && n < 60);
    `CHECK(ctrl.write_opcode_pulse, 1'b1, "no opcode load")
  endtask

  // Sets register B and the operand just after the next rising edge
  task automatic set_lines(input logic [15:0] b, input logic [15:0] d);
    @(posedge clk);
    reg_b     <= b;
    data_word <= d;
  endtask

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  logic [15:0] codes [4] = '{16'h4000, 16'h8000, 16'h3E00, 16'hFFFF};
  logic [15:0] brv [3] = '{16'h4000, 16'h8000, 16'h0001};
  logic [1:0]  brx [3] = '{2'h1, 2'h2, 2'h0};
  logic [6:0]  f_op [3] = '{7'h00, 7'h00, 7'h47};
  logic [2:0]  f_st [3] = '{3'h1, 3'h3, 3'h0};
  logic [2:0]  dv_st [6] = '{3'h1, 3'h3, 3'h7, 3'h6, 3'h4, 3'h2};

  initial begin
    logic [31:0] r;
    logic [11:0] held;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    // Register defaults and an unmapped place
    wb_xfer(1'b0, 4'h0, 32'h0, r);
    `CHECK(r[0], 1'b1, "run default")
    wb_xfer(1'b0, 4'h4, 32'h0, r);
    `CHECK(r[13:0], 14'h0000, "status after reset")
    wb_xfer(1'b1, 4'h8, 32'h0, r);
    wb_xfer(1'b0, 4'h8, 32'h0, r);
    `CHECK(r, 32'h0, "unmapped read")
    wb_xfer(1'b0, 4'h0, 32'h0, r);
    `CHECK(r[0], 1'b1, "unmapped write landed")
    // Order codes from register B
    foreach (codes[i]) begin
      set_lines(codes[i], 16'h0000);
      wait_load();
      `CHECK(opcode, {1'b0, codes[i][15], codes[i][13:9]}, "opcode load")
      `CHECK(ctrl.read_b_pulse, 1'b1, "register B read")
      `CHECK(stage, 3'h0, "stage at start")
    end
    wb_xfer(1'b0, 4'h4, 32'h0, r);
    `CHECK(r[6:0], 7'h3F, "status opcode")
    // Transfer: action pulse at T01 fans out
    set_lines(16'h0000, 16'h0000);
    wait_load();
    wait_tp(1);
    `CHECK({ctrl.read_z_pulse, ctrl.write_q_pulse}, 2'h3, "transfer fan-out")
    // Special instructions by address
    for (int k = 0; k < 2; k++) begin
      set_lines(16'h0000, (k == 0) ? 16'h0003 : 16'h0004);
      wait_load();
      wait_tp(8);
      `CHECK(ctrl.interrupt_release_instruction, k == 0, "release pulse")
      `CHECK(ctrl.interrupt_inhibit_instruction, k == 1, "inhibit pulse")
    end
    // Extend makes the next load an extracode divide, bit 14 not loaded
    set_lines(16'h0000, 16'h0006);
    wait_load();
    set_lines(16'h5000, 16'h0006);
    wait_load();
    `CHECK(opcode, 7'h48, "extend bit")
    set_lines(16'h0000, 16'h0000);
    // Divide walks the Gray stages, then ends at 010
    foreach (dv_st[i]) begin
      wait_tp(0);
      `CHECK(stage, dv_st[i], "divide stage")
    end
    wait_load();
    `CHECK(opcode[6], 1'b0, "extend cleared")
    // Double add tests the write lines at T07
    foreach (brv[i]) begin
      set_lines(16'h2000, brv[i]);
      wait_load();
      wait_tp(5);
      `CHECK(ctrl.read_sum_pulse, 1'b1, "double add at T05")
      wait_tp(8);
      `CHECK(branch, brx[i], "branch value")
      wait_tp(9);
      `CHECK(ctrl.read_z_pulse, brx[i] == 2'h1, "branch extra pulse")
      wait_tp(0);
      `CHECK(stage, 3'h1, "double add second stage")
    end
    set_lines(16'h0000, 16'h0000);
    // Forced orders
    for (int f = 0; f < 3; f++) begin
      @(posedge clk);
      force_v <= 3'h1 << f;
      wait_tp(11);
      wait_tp(0);
      `CHECK(opcode, f_op[f], "forced opcode")
      `CHECK(stage, f_st[f], "forced stage")
      `CHECK({ctrl.read_b_pulse, ctrl.write_opcode_pulse}, 2'h0, "forced load blocked")
      @(posedge clk);
      force_v <= 3'h0;
      wait_load();
    end
    // Peripheral fetch is latched and runs two stages
    @(posedge clk);
    fetch_rq <= 1'b1;
    wait_tp(11);
    wait_tp(0);
    @(posedge clk);
    fetch_rq <= 1'b0;
    wait_tp(5);
    `CHECK(ctrl.periph_xfer_pulse, 1'b1, "fetch pulse")
    wait_tp(0);
    `CHECK(stage, 3'h1, "fetch second stage")
    wait_load();
    // Run off freezes the time pulses
    wb_xfer(1'b1, 4'h0, 32'h0, r);
    @(negedge clk);
    held = tp;
    repeat (5) @(negedge clk);
    `CHECK(tp, held, "time pulse frozen")
    `CHECK(ctrl, 16'h0000, "commands while stopped")
    wb_xfer(1'b1, 4'h0, 32'h1, r);
    wait_load();
    end_of_test();
  end

  initial begin
    #(10000 * 50);
    fail_count++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    end_of_test();
  end
endmodule

`default_nettype wire
